// File: hwc_top.sv
// Purpose: host wake controller: arming, wake detection, pin handshake, packet store
// Assumes: rx words and filter verdicts arrive synchronous to clk_i
// Notes: filters 4..7 are the flexible filters
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "hwc_cfg.svh"
module hwc_top #(
   parameter int RETX_CYC = `HWC_RETX_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // register port
   input wire logic [16:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // receive path and link
   input wire hwc_pkg::hwc_rx_t rx_i,
   input wire logic link_chg_i,
   // nonvolatile load of apm enable
   input wire logic nv_load_i,
   input wire logic nv_apm_wake_enable_bits_i,
   // power controller handshake
   input wire logic pin_release_i,
   input wire logic report_ack_i,
   output logic wake_request_pin_n_o,
   output logic report_o,
   output logic [15:0] report_src_o,
   // in-band wake message to the lan controller
   output logic inband_wake_o
);
   // configuration state
   logic capen_r; // wake capability enable
   logic armed_r; // host wake armed
   logic fta_r; // filter table access
   logic [15:0] wuc_r; // wake control
   logic [15:0] wus_r; // wake status
   logic [15:0] wake_filter_control_r; // wake filter control
   logic apmwol_r; // station address copy enable
   logic store_en_r; // packet storage enable
   logic [31:0] sal_r; // station address low
   logic [31:0] sah_r; // station address high
   logic [15:0] flex_r [0:3]; // flexible filter values
   // packet store
   logic [15:0] pkt_mem [0:63];
   logic [6:0] wcnt_r; // words captured in current packet
   logic stored_r; // packet held
   logic [15:0] len_r; // stored length in bytes
   // handshake and retransmit
   hwc_pkg::hwc_state_t st_r;
   logic pend_r; // wake waiting for next pin cycle
   logic [31:0] retx_r; // cycles to resend, zero when idle
   logic armed_q; // armed one cycle ago

   // decode helper
   function automatic logic hit(input logic [16:0] a, input logic [16:0] b);
      hit = (a == b);
   endfunction

   // page 800 reachable only with capability set
   logic wpage_ok;
   assign wpage_ok = (addr_i[16:7] != `HWC_PG_WAKE) || capen_r;
   logic wr_ok;
   assign wr_ok = wr_i && wpage_ok;

   // wake detection
   logic det_en, apm_wake_enable_bits, lnk_ok, magic_hit, lnk_hit, pkt_wake, wake_evt;
   logic [7:0] fmask, acpi_hits;
   assign det_en = armed_r && capen_r;
   assign apm_wake_enable_bits = wuc_r[`HWC_B_APM_WAKE_ENABLE_BITS];
   assign fmask = fta_r ? ~`HWC_FLEX_MASK : 8'hff;
   assign acpi_hits = (det_en && rx_i.vld && rx_i.eop && rx_i.addr_pass) ?
                      (rx_i.match & wake_filter_control_r[8:1] & fmask) : 8'h00;
   assign magic_hit = det_en && apm_wake_enable_bits && rx_i.vld && rx_i.eop && rx_i.magic;
   assign lnk_ok = wuc_r[`HWC_B_LINK_CHANGE_WAKE_ONLY] ? (apm_wake_enable_bits && wuc_r[`HWC_B_LINK_CHANGE_WAKE_ENABLE])
                                        : wake_filter_control_r[`HWC_B_LINK_CHANGED_FLAG];
   assign lnk_hit = det_en && link_chg_i && lnk_ok;
   assign pkt_wake = magic_hit || (acpi_hits != 8'h00);
   assign wake_evt = pkt_wake || lnk_hit;

   // port configuration register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capen_r <= 1'b0;
         armed_r <= 1'b0;
      end else if (wr_ok && hit(addr_i, `HWC_A_PORT)) begin
         capen_r <= wdata_i[`HWC_B_CAPEN];
         armed_r <= wdata_i[`HWC_B_ARMED];
      end
   end

   // receive control, filter control, storage enable
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fta_r <= 1'b0;
         wake_filter_control_r <= 16'h0000;
         store_en_r <= 1'b0;
      end else if (wr_ok) begin
         if (hit(addr_i, `HWC_A_RXCTL)) begin
            fta_r <= wdata_i[`HWC_B_FTA];
         end
         if (hit(addr_i, `HWC_A_WAKE_FILTER_CONTROL)) begin
            wake_filter_control_r <= wdata_i;
         end
         if (hit(addr_i, `HWC_A_STORE)) begin
            store_en_r <= wdata_i[`HWC_B_STORE];
         end
      end
   end

   // wake control: nonvolatile load wins over software write
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wuc_r <= 16'h0000;
      end else if (nv_load_i) begin
         wuc_r[`HWC_B_APM_WAKE_ENABLE_BITS] <= nv_apm_wake_enable_bits_i;
      end else if (wr_ok && hit(addr_i, `HWC_A_WUC)) begin
         wuc_r <= wdata_i;
      end
   end

   // flexible filter table, writable only while access bit set
   // cleared at reset so a refused write reads back as zero, not unknown
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < 4; i++) begin
            flex_r[i] <= 16'h0000;
         end
      end else if (wr_ok && fta_r && addr_i[16:2] == `HWC_A_FLEX0 >> 2) begin
         flex_r[addr_i[1:0]] <= wdata_i;
      end
   end

   // station address copy
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         apmwol_r <= 1'b0;
         sal_r <= 32'h00000000;
         sah_r <= 32'h00000000;
      end else if (wr_i) begin
         if (hit(addr_i, `HWC_A_APMCTL)) begin
            apmwol_r <= wdata_i[`HWC_B_APMWOL];
         end
         if (apmwol_r && hit(addr_i, `HWC_A_STA0)) begin
            sal_r[15:0] <= wdata_i;
         end
         if (apmwol_r && hit(addr_i, `HWC_A_STA1)) begin
            sal_r[31:16] <= wdata_i;
         end
         if (apmwol_r && hit(addr_i, `HWC_A_STA2)) begin
            sah_r[15:0] <= wdata_i;
            sah_r[`HWC_B_AVALID] <= 1'b1;
         end
      end
   end

   // wake status: hardware set wins over write-one clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wus_r <= 16'h0000;
      end else begin
         wus_r <= (wus_r & ~((wr_ok && hit(addr_i, `HWC_A_WUS)) ? wdata_i : 16'h0000))
                  | {6'h00, acpi_hits, magic_hit, lnk_hit};
      end
   end

   // packet capture word counter
   logic cap_ok;
   assign cap_ok = store_en_r && det_en && !stored_r;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wcnt_r <= 7'h00;
      end else if (rx_i.vld) begin
         if (rx_i.eop) begin
            wcnt_r <= 7'h00;
         end else if (rx_i.sop) begin
            wcnt_r <= 7'h01;
         end else if (wcnt_r != `HWC_PKT_WORDS) begin
            wcnt_r <= wcnt_r + 7'h01;
         end
      end
   end

   // packet memory writes, only while nothing is held
   logic [6:0] widx;
   assign widx = rx_i.sop ? 7'h00 : wcnt_r;
   always_ff @(posedge clk_i) begin
      if (rx_i.vld && cap_ok && widx != `HWC_PKT_WORDS) begin
         pkt_mem[widx[5:0]] <= rx_i.data;
      end
   end

   // stored indication and length
   logic [15:0] blen;
   assign blen = (widx == `HWC_PKT_WORDS) ? `HWC_PKT_MAXB : {8'h00, widx + 7'h01, 1'b0};
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stored_r <= 1'b0;
         len_r <= 16'h0000;
      end else if (cap_ok && pkt_wake) begin
         stored_r <= 1'b1;
         len_r <= blen;
      end else if (wr_i && hit(addr_i, `HWC_A_PKT_CLR)) begin
         stored_r <= 1'b0;
         len_r <= 16'h0000;
      end
   end

   // pin handshake with the power controller
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= hwc_pkg::ST_IDLE;
         pend_r <= 1'b0;
      end else begin
         case (st_r)
            hwc_pkg::ST_IDLE: begin
               if (wake_evt || pend_r) begin
                  st_r <= hwc_pkg::ST_PIN;
                  pend_r <= 1'b0;
               end
            end
            hwc_pkg::ST_PIN: begin
               if (pin_release_i) begin
                  st_r <= hwc_pkg::ST_WAIT_ACK;
               end
            end
            hwc_pkg::ST_WAIT_ACK: begin
               if (wake_evt) begin
                  pend_r <= 1'b1;
               end
               if (report_ack_i) begin
                  st_r <= hwc_pkg::ST_IDLE;
               end
            end
            default: begin
               st_r <= hwc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // report on every release message, with status snapshot
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         report_o <= 1'b0;
         report_src_o <= 16'h0000;
      end else begin
         report_o <= pin_release_i;
         if (pin_release_i) begin
            report_src_o <= wus_r;
         end
      end
   end

   // pin is low only while a request stands
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_request_pin_n_o <= 1'b1;
      end else begin
         wake_request_pin_n_o <= !((st_r == hwc_pkg::ST_IDLE && (wake_evt || pend_r))
                                 || (st_r == hwc_pkg::ST_PIN && !pin_release_i));
      end
   end

   // in-band message and its retransmit timer
   logic retx_fire;
   assign retx_fire = (retx_r == 32'h00000001) && armed_r == armed_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         retx_r <= 32'h00000000;
         armed_q <= 1'b0;
         inband_wake_o <= 1'b0;
      end else begin
         armed_q <= armed_r;
         inband_wake_o <= wake_evt || retx_fire;
         if (wake_evt || retx_fire) begin
            retx_r <= RETX_CYC[31:0];
         end else if (armed_r != armed_q) begin
            retx_r <= 32'h00000000;
         end else if (retx_r != 32'h00000000) begin
            retx_r <= retx_r - 32'h00000001;
         end
      end
   end

   // read data, one cycle after the strobe
   logic [15:0] rd_nxt;
   always_comb begin
      rd_nxt = 16'h0000;
      if (!wpage_ok) begin
         rd_nxt = 16'h0000;
      end else if (addr_i[16:7] == `HWC_PG_PKT && !addr_i[6]) begin
         rd_nxt = pkt_mem[addr_i[5:0]];
      end else if (hit(addr_i, `HWC_A_PKT_LEN)) begin
         rd_nxt = len_r;
      end else if (hit(addr_i, `HWC_A_PORT)) begin
         rd_nxt[`HWC_B_CAPEN] = capen_r;
         rd_nxt[`HWC_B_ARMED] = armed_r;
      end else if (hit(addr_i, `HWC_A_RXCTL)) begin
         rd_nxt[`HWC_B_FTA] = fta_r;
      end else if (hit(addr_i, `HWC_A_WUC)) begin
         rd_nxt = wuc_r;
      end else if (hit(addr_i, `HWC_A_WUS)) begin
         rd_nxt = wus_r;
      end else if (hit(addr_i, `HWC_A_WAKE_FILTER_CONTROL)) begin
         rd_nxt = wake_filter_control_r;
         if (wuc_r[`HWC_B_LINK_CHANGE_WAKE_ONLY] && !(apm_wake_enable_bits && wuc_r[`HWC_B_LINK_CHANGE_WAKE_ENABLE])) begin
            rd_nxt[`HWC_B_LINK_CHANGED_FLAG] = 1'b0;
         end
      end else if (hit(addr_i, `HWC_A_SAL_LO)) begin
         rd_nxt = sal_r[15:0];
      end else if (hit(addr_i, `HWC_A_SAL_HI)) begin
         rd_nxt = sal_r[31:16];
      end else if (hit(addr_i, `HWC_A_SAH_LO)) begin
         rd_nxt = sah_r[15:0];
      end else if (hit(addr_i, `HWC_A_SAH_HI)) begin
         rd_nxt = sah_r[31:16];
      end else if (addr_i[16:2] == `HWC_A_FLEX0 >> 2) begin
         rd_nxt = flex_r[addr_i[1:0]];
      end else if (hit(addr_i, `HWC_A_APMCTL)) begin
         rd_nxt[`HWC_B_APMWOL] = apmwol_r;
      end else if (hit(addr_i, `HWC_A_STORE)) begin
         rd_nxt[`HWC_B_STORE] = store_en_r;
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         rdata_o <= rd_nxt;
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_wake_idle;
      st_r == hwc_pkg::ST_IDLE && wake_evt;
   endsequence
   sequence s_pin_low;
      !wake_request_pin_n_o && st_r == hwc_pkg::ST_PIN;
   endsequence
   AST_WAKE_PIN: assert property (s_wake_idle |=> s_pin_low)
      else $error("wake event did not pull request pin low");
   AST_ARMED_ONLY: assert property (wake_evt |-> armed_r && capen_r)
      else $error("wake detected while not armed");
   AST_RELEASE: assert property (pin_release_i |=> report_o && wake_request_pin_n_o)
      else $error("release not followed by report and pin release");
   AST_NO_REARM: assert property (st_r == hwc_pkg::ST_WAIT_ACK && !report_ack_i
                                  |=> wake_request_pin_n_o)
      else $error("pin reasserted before report acknowledge");
   AST_KEEP_PKT: assert property (stored_r && !(wr_i && hit(addr_i, `HWC_A_PKT_CLR))
                                  |=> stored_r && $stable(len_r))
      else $error("stored wake packet overwritten");
   AST_RETX: assert property (retx_r == 32'h00000001 && armed_r == armed_q |=> inband_wake_o)
      else $error("retransmit missing");
   AST_AVALID: assert property (wr_i && apmwol_r && hit(addr_i, `HWC_A_STA2)
                                |=> sah_r[`HWC_B_AVALID])
      else $error("address valid not set");
   AST_LNK_ZERO: assert property (rd_i && hit(addr_i, `HWC_A_WAKE_FILTER_CONTROL) && capen_r &&
                                  wuc_r[`HWC_B_LINK_CHANGE_WAKE_ONLY] && !(apm_wake_enable_bits && wuc_r[`HWC_B_LINK_CHANGE_WAKE_ENABLE])
                                  |=> rdata_o[`HWC_B_LINK_CHANGED_FLAG] == 1'b0)
      else $error("link bit read nonzero");
   AST_FLEX_OFF: assert property (fta_r |-> (acpi_hits & `HWC_FLEX_MASK) == 8'h00)
      else $error("flexible filter active during table access");
   AST_LNK_SET: assert property (lnk_hit |=> wus_r[`HWC_B_LINK_CHANGED_FLAG] && inband_wake_o)
      else $error("link change flag not set");
endmodule

// File: hwc_cfg.svh
// Purpose: register map, field positions and timing of the host wake controller
// Assumes: address is {page[9:0], register[6:0]}, data is 16 bits wide
// Notes: definitions only
`ifndef HWC_CFG_SVH
`define HWC_CFG_SVH
// register addresses
`define HWC_A_PORT {10'h301, 7'h11}
`define HWC_A_RXCTL {10'h320, 7'h00}
`define HWC_A_WUC {10'h320, 7'h01}
`define HWC_A_WUS {10'h320, 7'h02}
`define HWC_A_WAKE_FILTER_CONTROL {10'h320, 7'h03}
`define HWC_A_SAL_LO {10'h320, 7'h04}
`define HWC_A_SAL_HI {10'h320, 7'h05}
`define HWC_A_SAH_LO {10'h320, 7'h06}
`define HWC_A_SAH_HI {10'h320, 7'h07}
`define HWC_A_FLEX0 {10'h320, 7'h08}
`define HWC_A_APMCTL {10'h000, 7'h1a}
`define HWC_A_STA0 {10'h000, 7'h1b}
`define HWC_A_STA1 {10'h000, 7'h1c}
`define HWC_A_STA2 {10'h000, 7'h1d}
`define HWC_A_STORE {10'h304, 7'h19}
`define HWC_A_PKT_LEN {10'h323, 7'h40}
`define HWC_A_PKT_CLR {10'h323, 7'h42}
`define HWC_PG_WAKE 10'h320
`define HWC_PG_PKT 10'h323
// field positions
`define HWC_B_CAPEN 2
`define HWC_B_ARMED 4
`define HWC_B_FTA 2
`define HWC_B_APM_WAKE_ENABLE_BITS 0
`define HWC_B_LINK_CHANGE_WAKE_ENABLE 4
`define HWC_B_LINK_CHANGE_WAKE_ONLY 5
`define HWC_B_LINK_CHANGED_FLAG 0
`define HWC_B_MAGIC 1
`define HWC_B_APMWOL 10
`define HWC_B_STORE 4
`define HWC_B_AVALID 31
// masks and sizes
`define HWC_FLEX_MASK 8'hf0
`define HWC_PKT_WORDS 7'h40
`define HWC_PKT_MAXB 16'h0080
// retransmit period
`define HWC_RETX_MS 50
`define HWC_CLK_KHZ 125000
`define HWC_RETX_CYC (`HWC_RETX_MS * `HWC_CLK_KHZ)
`endif

// File: hwc_pkg.sv
// Purpose: types shared by the host wake controller
// Assumes: nothing
// Notes: constants live in hwc_cfg.svh
package hwc_pkg;
   // handshake state with the platform power controller
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PIN = 3'b010,
      ST_WAIT_ACK = 3'b100
   } hwc_state_t;
   // one received word plus end-of-packet filter verdicts
   typedef struct packed {
      logic vld;
      logic sop;
      logic eop;
      logic [15:0] data;
      logic magic;
      logic addr_pass;
      logic [7:0] match;
   } hwc_rx_t;
endpackage

// File: hwc_pmc_model.sv
// Purpose: power controller model on the far side of the wake pin
// Assumes: release and acknowledge are one-cycle pulses
// Notes: delays come from the bench so answers can be prompt or slow
`timescale 1ns/1ps
module hwc_pmc_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // answer delays in cycles
   input wire logic [7:0] rel_dly_i,
   input wire logic [7:0] ack_dly_i,
   // wake handshake
   input wire logic wake_request_pin_n_i,
   input wire logic report_i,
   output logic pin_release_o,
   output logic report_ack_o
);
   logic [7:0] rel_cnt_r; // cycles the pin has been low
   logic [7:0] ack_cnt_r; // cycles since the last report
   logic ack_due_r; // report seen, acknowledge owed
   // release message once the pin has been low for the set delay
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rel_cnt_r <= 8'h00;
         pin_release_o <= 1'b0;
      end else if (wake_request_pin_n_i || pin_release_o) begin
         rel_cnt_r <= 8'h00;
         pin_release_o <= 1'b0;
      end else begin
         rel_cnt_r <= rel_cnt_r + 8'h01;
         pin_release_o <= (rel_cnt_r == rel_dly_i);
      end
   end
   // acknowledge every report after the set delay
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_cnt_r <= 8'h00;
         ack_due_r <= 1'b0;
         report_ack_o <= 1'b0;
      end else begin
         report_ack_o <= ack_due_r && (ack_cnt_r == ack_dly_i);
         ack_cnt_r <= report_i ? 8'h00 : ack_cnt_r + 8'h01;
         if (report_i)
            ack_due_r <= 1'b1;
         else if (ack_cnt_r == ack_dly_i)
            ack_due_r <= 1'b0;
      end
   end
endmodule

// File: hwc_top_bench.sv
// Purpose: self-checking bench of the host wake controller
// Assumes: retransmit period shortened to 20 cycles
// Notes: inputs change by non-blocking assignment on rising edges
`timescale 1ns/1ps
`include "hwc_cfg.svh"
module hwc_top_bench;
   localparam int RETX = 20; // shortened retransmit period
   logic clk_i = 1'b0, arst_n_i = 1'b0; // clock, reset
   logic [16:0] addr_i = 17'h00000; // register port
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0, rd_i = 1'b0;
   hwc_pkg::hwc_rx_t rx_i = '0; // receive words
   logic link_chg_i = 1'b0, nv_load_i = 1'b0, nv_apm_wake_enable_bits_i = 1'b0;
   logic [7:0] rel_dly = 8'h04, ack_dly = 8'h1e; // partner delays
   logic [15:0] rdata_o, report_src_o; // design outputs
   logic wake_request_pin_n_o, report_o, inband_wake_o;
   logic pin_release_i, report_ack_i; // from partner
   int err_total = 0, tests_run = 0, n = 0, t0 = 0, cyc_r = 0;
   hwc_top #(.RETX_CYC(RETX)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .rx_i(rx_i), .link_chg_i(link_chg_i),
      .nv_load_i(nv_load_i), .nv_apm_wake_enable_bits_i(nv_apm_wake_enable_bits_i),
      .pin_release_i(pin_release_i), .report_ack_i(report_ack_i),
      .wake_request_pin_n_o(wake_request_pin_n_o), .report_o(report_o),
      .report_src_o(report_src_o), .inband_wake_o(inband_wake_o));
   hwc_pmc_model pmc (.clk_i(clk_i), .arst_n_i(arst_n_i), .rel_dly_i(rel_dly),
      .ack_dly_i(ack_dly), .wake_request_pin_n_i(wake_request_pin_n_o),
      .report_i(report_o), .pin_release_o(pin_release_i),
      .report_ack_o(report_ack_i));
   // clock and cycle count
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc_r <= cyc_r + 1;
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [16:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read, data judged in the cycle after the strobe
   task automatic rchk(input logic [16:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // one-cycle pulses on link change and nonvolatile load
   task automatic pulse_link;
      @(posedge clk_i);
      link_chg_i <= 1'b1;
      @(posedge clk_i);
      link_chg_i <= 1'b0;
      #1;
   endtask
   task automatic nv(input logic v);
      @(posedge clk_i);
      nv_load_i <= 1'b1;
      nv_apm_wake_enable_bits_i <= v;
      @(posedge clk_i);
      nv_load_i <= 1'b0;
   endtask
   // send a packet; verdicts ride on every word, judged at the last
   task automatic pkt(input int k, input logic [15:0] b, input logic mg,
                      input logic ps, input logic [7:0] m);
      hwc_pkg::hwc_rx_t w;
      for (int i = 0; i < k; i++) begin
         w = '0;
         w.vld = 1'b1;
         w.sop = (i == 0);
         w.eop = (i == k - 1);
         w.data = b + 16'(i);
         w.magic = mg;
         w.addr_pass = ps;
         w.match = m;
         @(posedge clk_i);
         rx_i <= w;
      end
      @(posedge clk_i);
      rx_i <= '0;
      #1;
   endtask
   // 0 pin low, 1 report, other in-band message
   function automatic logic probe(input int s);
      case (s)
         0: probe = !wake_request_pin_n_o;
         1: probe = report_o;
         default: probe = inband_wake_o;
      endcase
   endfunction
   task automatic wait_for(input int s, input int lim);
      n = 0;
      while (probe(s) !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask
   // page gating, table access, station address
   task automatic t_access;
      rchk(`HWC_A_PORT, 16'h0000);
      wr(`HWC_A_WUC, 16'h0031);
      rchk(`HWC_A_WUC, 16'h0000);
      wr(`HWC_A_PORT, 16'h0004);
      wr(`HWC_A_WUC, 16'h0031);
      rchk(`HWC_A_WUC, 16'h0031);
      wr(`HWC_A_FLEX0, 16'h00a5);
      rchk(`HWC_A_FLEX0, 16'h0000);
      wr(`HWC_A_RXCTL, 16'h0004);
      wr(`HWC_A_FLEX0, 16'h00a5);
      rchk(`HWC_A_FLEX0, 16'h00a5);
      wr(`HWC_A_STA0, 16'h1111);
      rchk(`HWC_A_SAL_LO, 16'h0000);
      wr(`HWC_A_APMCTL, 16'h0400);
      wr(`HWC_A_STA0, 16'h1111);
      wr(`HWC_A_STA1, 16'h2222);
      rchk(`HWC_A_SAH_HI, 16'h0000);
      wr(`HWC_A_STA2, 16'h3333);
      rchk(`HWC_A_SAL_LO, 16'h1111);
      rchk(`HWC_A_SAL_HI, 16'h2222);
      rchk(`HWC_A_SAH_LO, 16'h3333);
      rchk(`HWC_A_SAH_HI, 16'h8000);
      rchk({10'h3ff, 7'h7f}, 16'h0000);
   endtask
   // link wake, pin handshake, held event, retransmit
   task automatic t_link;
      wr(`HWC_A_WAKE_FILTER_CONTROL, 16'h0001);
      pulse_link();
      wait_for(0, 10);
      chk(16'(n), 16'd10);
      wr(`HWC_A_PORT, 16'h0014);
      pulse_link();
      t0 = cyc_r;
      chk(wake_request_pin_n_o, 1'b0);
      chk(inband_wake_o, 1'b1);
      rchk(`HWC_A_WUS, 16'h0001);
      wait_for(1, 20);
      chk(wake_request_pin_n_o, 1'b1);
      chk(report_src_o, 16'h0001);
      wait_for(2, 30);
      chk(16'(cyc_r - t0), 16'(RETX));
      pulse_link();
      wait_for(0, 8);
      chk(16'(n), 16'd8);
      wait_for(0, 30);
      chk(probe(0), 1'b1);
      ack_dly <= 8'h02;
      cyc(40);
      wr(`HWC_A_PORT, 16'h0004);
      rchk(`HWC_A_WUS, 16'h0001);
      cyc(2);
      wait_for(2, 30);
      chk(16'(n), 16'd30);
   endtask
   // link-only gating, nonvolatile load, magic wake
   task automatic t_apm;
      wr(`HWC_A_WUS, 16'hffff);
      wr(`HWC_A_WUC, 16'h0021);
      wr(`HWC_A_PORT, 16'h0014);
      rchk(`HWC_A_WAKE_FILTER_CONTROL, 16'h0000);
      pulse_link();
      wait_for(0, 10);
      chk(16'(n), 16'd10);
      rchk(`HWC_A_WUS, 16'h0000);
      nv(1'b0);
      rchk(`HWC_A_WUC, 16'h0020);
      pkt(2, 16'h0000, 1'b1, 1'b0, 8'h00);
      wait_for(0, 10);
      chk(16'(n), 16'd10);
      nv(1'b1);
      rchk(`HWC_A_WUC, 16'h0021);
      pkt(2, 16'h0000, 1'b1, 1'b0, 8'h00);
      wait_for(0, 10);
      chk(probe(0), 1'b1);
      rchk(`HWC_A_WUS, 16'h0002);
      cyc(40);
      wr(`HWC_A_WUC, 16'h0000);
      rchk(`HWC_A_WUC, 16'h0000);
   endtask
   // filter wake and stored packet
   task automatic t_store;
      wr(`HWC_A_PORT, 16'h0004);
      wr(`HWC_A_WUS, 16'hffff);
      wr(`HWC_A_STORE, 16'h0010);
      wr(`HWC_A_WAKE_FILTER_CONTROL, 16'h0020);
      wr(`HWC_A_PORT, 16'h0014);
      pkt(3, 16'h1000, 1'b0, 1'b1, 8'h10);
      wait_for(0, 10);
      chk(16'(n), 16'd10);
      wr(`HWC_A_RXCTL, 16'h0000);
      pkt(3, 16'h1000, 1'b0, 1'b0, 8'h10);
      wait_for(0, 10);
      chk(16'(n), 16'd10);
      pkt(3, 16'h1000, 1'b0, 1'b1, 8'h10);
      wait_for(0, 10);
      chk(probe(0), 1'b1);
      rchk(`HWC_A_WUS, 16'h0040);
      rchk(`HWC_A_PKT_LEN, 16'h0006);
      rchk({10'h323, 7'h02}, 16'h1002);
      cyc(40);
      pkt(2, 16'h2000, 1'b0, 1'b1, 8'h10);
      rchk(`HWC_A_PKT_LEN, 16'h0006);
      rchk({10'h323, 7'h00}, 16'h1000);
      wr(`HWC_A_PKT_CLR, 16'h0000);
      rchk(`HWC_A_PKT_LEN, 16'h0000);
   endtask
   // verdict and end of run
   task automatic complete_run;
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 chk(wake_request_pin_n_o, 1'b1);
      t_access();
      t_link();
      t_apm();
      t_store();
      complete_run();
   end
   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      complete_run();
   end
endmodule
